// ### dhbpc_top.sv
/*
 * Dual H-bridge PWM control logic: two bridge channels, input
 * synchronisers, sleep and wake timing, thermal and supply lockout, the
 * open-drain fault pin and an AXI4-Lite register slave.
 * Assumes the analog detectors deliver digital flags with their own
 * hysteresis, and an external pull-up on the fault pin.
 */
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
// Overview of operation
// - Two independent channels, each driven only by its own inputs.
// - Decode 00 coast, 01 reverse, 10 forward, 11 brake.
// - Chopping runs at a fixed 25 us period, starting with drive.
// - Comparator trip turns bridge off until the next period.
// - Sense comparator ignored for 2.4 us after each bridge enable; blanking here restarts only at each period start.
// - Comparator trips at 200 mV; grounded sense disables limiting.
// - Sleep low turns bridges off, resets logic, halts timers.
// - Other inputs ignored while asleep.
// - About 1 ms after wake before bridges respond.
// - Qualified overcurrent shuts that bridge and pulls fault low.
// - After retry time bridge re-enables; repeats while it persists.
// - Overcurrent shuts only the bridge that saw it.
// - Overcurrent path is separate from chopping comparator.
// - Over-temperature turns all bridges off and pulls fault low; fault here pulled only once the wake delay has ended.
// - Thermal trip near 160 C, resume after 45 C drop.
// - Supply lockout turns everything off and resets the logic.
// - Fault pin is open-drain, only ever pulled low.
`timescale 1ns/10ps
module dhbpc_top #(
    parameter int RETRY_CYC = dhbpc_pkg::RETRY_CYC,
    parameter int WAKE_CYC  = dhbpc_pkg::WAKE_CYC
) (
    input  wire logic        aclk,                   // 20 MHz clock.
    input  wire logic        aresetn,                // Sync reset, low.
    input  wire logic        sleep_request_low,      // Sleep pin, low.
    input  wire logic        chan_a_input_first,     // Channel A in 1.
    input  wire logic        chan_a_input_second,    // Channel A in 2.
    input  wire logic        chan_b_input_first,     // Channel B in 1.
    input  wire logic        chan_b_input_second,    // Channel B in 2.
    input  wire logic        chop_trip_a,            // A sense trip.
    input  wire logic        chop_trip_b,            // B sense trip.
    input  wire logic        over_cur_a,             // A overcurrent.
    input  wire logic        over_cur_b,             // B overcurrent.
    input  wire logic        thermal_shutdown,       // Overheat flag.
    input  wire logic        supply_lockout,         // Undervoltage.
    output logic             chan_a_output_first,    // A out 1 level.
    output logic             chan_a_output_first_oe, // A out 1 driven.
    output logic             chan_a_output_second,   // A out 2 level.
    output logic             chan_a_output_second_oe,// A out 2 driven.
    output logic             chan_b_output_first,    // B out 1 level.
    output logic             chan_b_output_first_oe, // B out 1 driven.
    output logic             chan_b_output_second,   // B out 2 level.
    output logic             chan_b_output_second_oe,// B out 2 driven.
    output logic             fault_flag_low,         // Always low.
    output logic             fault_flag_low_oe,      // Pull-down on.
    input  wire logic [3:0]  s_axi_awaddr,           // Write address.
    input  wire logic        s_axi_awvalid,          // Address valid.
    output logic             s_axi_awready,          // Address taken.
    input  wire logic [31:0] s_axi_wdata,            // Write data.
    input  wire logic [3:0]  s_axi_wstrb,            // Byte enables.
    input  wire logic        s_axi_wvalid,           // Data valid.
    output logic             s_axi_wready,           // Data taken.
    output logic [1:0]       s_axi_bresp,            // Write response.
    output logic             s_axi_bvalid,           // Response valid.
    input  wire logic        s_axi_bready,           // Response taken.
    input  wire logic [3:0]  s_axi_araddr,           // Read address.
    input  wire logic        s_axi_arvalid,          // Address valid.
    output logic             s_axi_arready,          // Address taken.
    output logic [31:0]      s_axi_rdata,            // Read data.
    output logic [1:0]       s_axi_rresp,            // Read response.
    output logic             s_axi_rvalid,           // Data valid.
    input  wire logic        s_axi_rready            // Data taken.
);
    localparam int W = dhbpc_pkg::SYNC_W;

    logic [W-1:0] raw;
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic         lrst;
    logic         awake;
    logic         run;
    logic [15:0]  wake_reg;
    logic [1:0]   ctrl_reg;
    logic         ocp_a;
    logic         ocp_b;
    logic         chop_a;
    logic         chop_b;
    logic [3:0]   aw_addr_reg;
    logic         aw_held_reg;
    logic [31:0]  w_data_reg;
    logic [3:0]   w_strb_reg;
    logic         w_held_reg;
    logic [31:0]  status;

    // Named views of the synchronised pins.
    logic s_sleep_n;
    logic s_a1;
    logic s_a2;
    logic s_b1;
    logic s_b2;
    logic s_trip_a;
    logic s_trip_b;
    logic s_oc_a;
    logic s_oc_b;
    logic s_hot;
    logic s_uv;

    // ========================================================
    // Input synchronisers. The first stage feeds only the second, so a
    // metastable sample never reaches decode or counters.
    assign raw = {sleep_request_low, chan_a_input_first,
                  chan_a_input_second, chan_b_input_first,
                  chan_b_input_second, chop_trip_a, chop_trip_b,
                  over_cur_a, over_cur_b, thermal_shutdown,
                  supply_lockout};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= raw;
            sync_reg <= meta_reg;
        end
    end

    assign {s_sleep_n, s_a1, s_a2, s_b1, s_b2, s_trip_a, s_trip_b,
            s_oc_a, s_oc_b, s_hot, s_uv} = sync_reg;

    // ========================================================
    // Sleep and lockout hold the motor logic in reset; the register
    // file stays alive so software can still read why.
    assign lrst = !aresetn || !s_sleep_n || s_uv;

    // Wake delay counts only after sleep and lockout release.
    always_ff @(posedge aclk) begin
        if (lrst) begin
            wake_reg <= 16'h0000;
        end else if (wake_reg != 16'(WAKE_CYC)) begin
            wake_reg <= wake_reg + 16'h0001;
        end
    end

    assign awake = (wake_reg == 16'(WAKE_CYC));
    // Thermal flag carries its own 45 C hysteresis from the detector.
    assign run   = awake && !s_hot;

    // ========================================================
    // Bridge channels, each fed only by its own pins.
    dhbpc_bridge #(.RETRY_CYC(RETRY_CYC)) u_chan_a (
        .aclk       (aclk),
        .lrst       (lrst),
        .run        (run),
        .chop_en    (ctrl_reg[dhbpc_pkg::CTRL_CHOP_A]),
        .in_first   (s_a1),
        .in_second  (s_a2),
        .chop_trip  (s_trip_a),
        .over_cur   (s_oc_a),
        .out_first  (chan_a_output_first),
        .out_second (chan_a_output_second),
        .oe_first   (chan_a_output_first_oe),
        .oe_second  (chan_a_output_second_oe),
        .ocp_shut   (ocp_a),
        .chop_off   (chop_a)
    );

    dhbpc_bridge #(.RETRY_CYC(RETRY_CYC)) u_chan_b (
        .aclk       (aclk),
        .lrst       (lrst),
        .run        (run),
        .chop_en    (ctrl_reg[dhbpc_pkg::CTRL_CHOP_B]),
        .in_first   (s_b1),
        .in_second  (s_b2),
        .chop_trip  (s_trip_b),
        .over_cur   (s_oc_b),
        .out_first  (chan_b_output_first),
        .out_second (chan_b_output_second),
        .oe_first   (chan_b_output_first_oe),
        .oe_second  (chan_b_output_second_oe),
        .ocp_shut   (ocp_b),
        .chop_off   (chop_b)
    );

    // ========================================================
    // Open-drain fault pin: level is always low, only the enable moves.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_flag_low    <= 1'b0;
            fault_flag_low_oe <= 1'b0;
        end else begin
            fault_flag_low    <= 1'b0;
            fault_flag_low_oe <= ocp_a || ocp_b || (awake && s_hot);
        end
    end

    // ========================================================
    // AXI4-Lite write path. Address and data are caught in either
    // order; the response issues once both are held.
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (aw_held_reg && w_held_reg) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (aw_held_reg && w_held_reg) begin
            w_held_reg <= 1'b0;
        end
    end

    // Commit and respond; only the low byte carries control bits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg     <= dhbpc_pkg::CTRL_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dhbpc_pkg::RESP_OKAY;
        end else if (aw_held_reg && w_held_reg) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg == dhbpc_pkg::CTRL_ADDR) begin
                s_axi_bresp <= dhbpc_pkg::RESP_OKAY;
                if (w_strb_reg[0]) begin
                    ctrl_reg <= w_data_reg[1:0];
                end
            end else if (aw_addr_reg == dhbpc_pkg::STATUS_ADDR) begin
                s_axi_bresp <= dhbpc_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= dhbpc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================================
    // AXI4-Lite read path, answered one cycle after the address.
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        status = 32'h0000_0000;
        status[dhbpc_pkg::ST_OCP_A]  = ocp_a;
        status[dhbpc_pkg::ST_OCP_B]  = ocp_b;
        status[dhbpc_pkg::ST_HOT]    = s_hot;
        status[dhbpc_pkg::ST_AWAKE]  = awake;
        status[dhbpc_pkg::ST_CHOP_A] = chop_a;
        status[dhbpc_pkg::ST_CHOP_B] = chop_b;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= dhbpc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= dhbpc_pkg::RESP_OKAY;
            if (s_axi_araddr == dhbpc_pkg::CTRL_ADDR) begin
                s_axi_rdata <= {30'h0000_0000, ctrl_reg};
            end else if (s_axi_araddr == dhbpc_pkg::STATUS_ADDR) begin
                s_axi_rdata <= status;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= dhbpc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================================
    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sleep_off_a: assert property (!s_sleep_n |=> !chan_a_output_first_oe
        && !chan_a_output_second_oe && !chan_b_output_first_oe
        && !chan_b_output_second_oe) else $error("driving asleep");
    wake_wait_a: assert property ($rose(s_sleep_n) && !s_uv
        |=> !awake [*8]) else $error("woke too soon");
    hot_off_a: assert property (s_hot |=> !chan_a_output_first_oe
        && !chan_b_output_first_oe && !chan_a_output_second_oe
        && !chan_b_output_second_oe) else $error("hot but driving");
    uv_reset_a: assert property (s_uv |=> wake_reg == 16'h0000)
        else $error("lockout kept state");
    fault_low_a: assert property ($rose(ocp_a) |=> fault_flag_low_oe
        && !fault_flag_low) else $error("fault not pulled");
    fault_od_a: assert property (!fault_flag_low)
        else $error("fault pin driven high");
    ocp_alone_a: assert property (ocp_a && !ocp_b && run && !lrst
        && s_b1 && s_b2 |=> chan_b_output_first_oe)
        else $error("other bridge stopped");
    ocp_off_a: assert property ($rose(ocp_a) |=> !chan_a_output_first_oe
        && !chan_a_output_second_oe) else $error("bridge left on");
    wake_cov: cover property ($rose(awake));
    fault_cov: cover property ($fell(fault_flag_low_oe));
    write_cov: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ### dhbpc_pkg.sv
/*
 * Shared constants for the dual H-bridge PWM control block: register map,
 * field positions, reset values and timing counts.
 * Assumes a 20 MHz system clock; every count below derives from it.
 */
package dhbpc_pkg;
    // ========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CHOP_PERIOD_NS = 25000;
    localparam int BLANK_NS       = 2400;
    localparam int OCP_DEG_NS     = 1500;
    localparam int OCP_RETRY_NS   = 1900000;
    localparam int WAKE_NS        = 1000000;
    // Period is exact; least times round up, longest times round down.
    localparam int CHOP_CYC  = CHOP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEG_CYC   = (OCP_DEG_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int RETRY_CYC = (OCP_RETRY_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int WAKE_CYC  = WAKE_NS / CLK_PERIOD_NS;
    // Analog figures, kept for reference; the comparators are off-chip.
    localparam int CHOP_REF_MV    = 200;
    localparam int THERM_TRIP_C   = 160;
    localparam int THERM_HYST_C   = 45;
    // ========================================================
    // Register map (byte addresses)
    localparam logic [3:0] CTRL_ADDR   = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [1:0] CTRL_RST    = 2'h3;
    localparam int CTRL_CHOP_A   = 0;
    localparam int CTRL_CHOP_B   = 1;
    localparam int ST_OCP_A      = 0;
    localparam int ST_OCP_B      = 1;
    localparam int ST_HOT        = 2;
    localparam int ST_AWAKE      = 3;
    localparam int ST_CHOP_A     = 4;
    localparam int ST_CHOP_B     = 5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Synchroniser vector layout.
    localparam int SYNC_W = 11;
endpackage

// ### dhbpc_bridge.sv
/*
 * One H-bridge channel: input decode, fixed-period current chopping with
 * blanking, and overcurrent shutdown with timed retry.
 * Assumes all inputs are already synchronised to aclk.
 */
`timescale 1ns/10ps
module dhbpc_bridge #(
    parameter int RETRY_CYC = dhbpc_pkg::RETRY_CYC
) (
    input  wire logic aclk,       // System clock.
    input  wire logic lrst,       // Logic reset, active high.
    input  wire logic run,        // Awake and not overheated.
    input  wire logic chop_en,    // Current chopping enable.
    input  wire logic in_first,   // First logic input.
    input  wire logic in_second,  // Second logic input.
    input  wire logic chop_trip,  // Sense comparator tripped.
    input  wire logic over_cur,   // Overcurrent detector.
    output logic      out_first,  // First output level.
    output logic      out_second, // Second output level.
    output logic      oe_first,   // First output driven.
    output logic      oe_second,  // Second output driven.
    output logic      ocp_shut,   // Bridge shut by overcurrent.
    output logic      chop_off    // Bridge off until next period.
);
    logic [9:0]  period_reg;
    logic [5:0]  blank_reg;
    logic [4:0]  deg_reg;
    logic [15:0] retry_reg;
    logic        start;
    logic        driving;

    assign start   = (period_reg == 10'h000);
    assign driving = in_first ^ in_second;

    // ========================================================
    // Chopping period and blanking; timers halt while not running.
    always_ff @(posedge aclk) begin
        if (lrst || !run) begin
            period_reg <= 10'h000;
        end else if (period_reg == 10'(dhbpc_pkg::CHOP_CYC - 1)) begin
            period_reg <= 10'h000;
        end else begin
            period_reg <= period_reg + 10'h001;
        end
    end

    // Blanking reloads at every period start so switching spikes pass.
    always_ff @(posedge aclk) begin
        if (lrst || !run || start) begin
            blank_reg <= 6'(dhbpc_pkg::BLANK_CYC);
        end else if (blank_reg != 6'h00) begin
            blank_reg <= blank_reg - 6'h01;
        end
    end

    // Trip turns the bridge off until the period restarts.
    always_ff @(posedge aclk) begin
        if (lrst || !run || start) begin
            chop_off <= 1'b0;
        end else if (chop_en && driving && chop_trip
                     && blank_reg == 6'h00) begin
            chop_off <= 1'b1;
        end
    end

    // ========================================================
    // Overcurrent qualification and retry, apart from chopping.
    always_ff @(posedge aclk) begin
        if (lrst) begin
            deg_reg   <= 5'h00;
            retry_reg <= 16'h0000;
            ocp_shut  <= 1'b0;
        end else if (ocp_shut) begin
            if (retry_reg == 16'(RETRY_CYC - 1)) begin
                ocp_shut  <= 1'b0;
                retry_reg <= 16'h0000;
            end else begin
                retry_reg <= retry_reg + 16'h0001;
            end
        end else if (over_cur) begin
            if (deg_reg == 5'(dhbpc_pkg::DEG_CYC - 1)) begin
                ocp_shut <= 1'b1;
                deg_reg  <= 5'h00;
            end else begin
                deg_reg <= deg_reg + 5'h01;
            end
        end else begin
            deg_reg <= 5'h00;
        end
    end

    // ========================================================
    // Output decode; coast, chop-off while driving and shutdown all release both pins.
    always_ff @(posedge aclk) begin
        if (lrst || !run || ocp_shut) begin
            {out_first, out_second} <= 2'h0;
            {oe_first, oe_second}   <= 2'h0;
        end else begin
            case ({in_first, in_second})
                2'b01: begin
                    {out_first, out_second} <= 2'h1;
                    {oe_first, oe_second}   <= {2{!chop_off}};
                end
                2'b10: begin
                    {out_first, out_second} <= 2'h2;
                    {oe_first, oe_second}   <= {2{!chop_off}};
                end
                2'b11: begin
                    {out_first, out_second} <= 2'h0;
                    {oe_first, oe_second}   <= 2'h3;
                end
                default: begin
                    {out_first, out_second} <= 2'h0;
                    {oe_first, oe_second}   <= 2'h0;
                end
            endcase
        end
    end

    // ========================================================
    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (lrst);

    decode_fwd_a: assert property (run && !ocp_shut && !chop_off
        && in_first && !in_second |=> out_first && !out_second
        && oe_first && oe_second) else $error("forward decode wrong");
    coast_z_a: assert property (!in_first && !in_second
        |=> !oe_first && !oe_second) else $error("coast not released");
    blank_hold_a: assert property (blank_reg != 6'h00 && !chop_off
        |=> !chop_off) else $error("trip inside blanking");
    chop_stay_a: assert property (chop_off && run
        && period_reg != 10'h000
        |=> chop_off) else $error("chop released early");
    ocp_retry_a: assert property ($fell(ocp_shut) && !$past(lrst)
        |-> $past(retry_reg) == 16'(RETRY_CYC - 1))
        else $error("retry time wrong");
    ocp_deg_a: assert property ($rose(ocp_shut)
        |-> $past(over_cur, 1) && $past(deg_reg) == 5'(dhbpc_pkg::DEG_CYC - 1))
        else $error("overcurrent not qualified");
    chop_cov: cover property ($rose(chop_off));
    ocp_cov: cover property ($fell(ocp_shut));
endmodule

// ### dhbpc_mcu.sv
/* Controller model: puts a drive code per channel onto its two inputs.
   Assumes the bench changes the codes just after a rising edge. */
`timescale 1ns/10ps
module dhbpc_mcu (
    input  wire logic [1:0] code_a,              // Channel A code.
    input  wire logic [1:0] code_b,              // Channel B code.
    output logic            chan_a_input_first,  // A first input.
    output logic            chan_a_input_second, // A second input.
    output logic            chan_b_input_first,  // B first input.
    output logic            chan_b_input_second  // B second input.
);
    // ========
    // Each code goes straight onto its two inputs, high bit on the first input.
    assign {chan_a_input_first, chan_a_input_second} = code_a;
    assign {chan_b_input_first, chan_b_input_second} = code_b;
endmodule

// ### test_dual_hbridge_pwm_control.sv
/* Bench for the H-bridge control block: registers, decode, faults, sleep.
   Assumes short wake and retry counts on the instance. */
`timescale 1ns/10ps
module test_dual_hbridge_pwm_control;
    logic aclk = 0, aresetn = 0, sleep_request_low = 1, supply_lockout = 0;
    logic chop_trip_a = 0, chop_trip_b = 0, over_cur_a = 0, over_cur_b = 0;
    logic thermal_shutdown = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, fault_flag_low, fault_flag_low_oe;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, code_a = 2'h0, code_b = 2'h0;
    logic chan_a_input_first, chan_a_input_second, chan_b_input_first;
    logic chan_b_input_second, chan_a_output_first, chan_a_output_second;
    logic chan_b_output_first, chan_b_output_second, chan_a_output_first_oe;
    logic chan_a_output_second_oe, chan_b_output_first_oe;
    logic chan_b_output_second_oe;
    int num_errors = 0, checked = 0, n1, n2;
    localparam logic [3:0] DEC [4] = '{4'h0, 4'h7, 4'hB, 4'h3};
    // ========
    // Pin levels are masked where undriven, since a Z pin has no level.
    wire [3:0] va = {chan_a_output_first & chan_a_output_first_oe,
        chan_a_output_second & chan_a_output_second_oe,
        chan_a_output_first_oe, chan_a_output_second_oe};
    wire [3:0] vb = {chan_b_output_first & chan_b_output_first_oe,
        chan_b_output_second & chan_b_output_second_oe,
        chan_b_output_first_oe, chan_b_output_second_oe};
    always #25 aclk = ~aclk;
    dhbpc_mcu i_dhbpc_mcu (.*);
    dhbpc_top #(.RETRY_CYC(50), .WAKE_CYC(20)) i_dhbpc_top (.*);
    task automatic chk(input string s, input logic [39:0] g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // One register access; ready and response are taken at the edge.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        logic dn;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(posedge aclk);
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            rs = w ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!dn);
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    // Counts edges until channel A's first enable leaves level v.
    task automatic span(input logic v, output int k);
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (chan_a_output_first_oe === v && k < 1000);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("ready", {s_axi_awready, s_axi_wready, s_axi_arready},
            3'h7);
        bus(1'b0, 4'h0, 32'h0);
        chk("ctrl", {rs, rd}, {2'h0, 32'h3});
        bus(1'b0, 4'h8, 32'h0);
        chk("unmapped", {rs, rd}, {2'h2, 32'h0});
        bus(1'b1, 4'h0, 32'h0);
        chk("wresp", rs, 2'h0);
        repeat (40) @(posedge aclk);
        bus(1'b0, 4'h4, 32'h0);
        chk("status", {rs, rd}, {2'h0, 32'h8});
        for (int c = 0; c < 4; c++) begin
            code_a <= 2'(c);
            code_b <= ~2'(c);
            repeat (5) @(posedge aclk);
            chk("decode", {va, vb}, {DEC[c], DEC[3 - c]});
        end
        {code_a, code_b, over_cur_a} <= {2'h2, 2'h1, 1'b1};
        repeat (40) @(posedge aclk);
        chk("ocp", {va, vb, fault_flag_low_oe, fault_flag_low},
            {4'h0, DEC[1], 2'h2});
        over_cur_a <= 1'b0;
        repeat (60) @(posedge aclk);
        chk("retry", {va, fault_flag_low_oe}, {DEC[2], 1'b0});
        thermal_shutdown <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("hot", {va, vb, fault_flag_low_oe}, 9'h1);
        thermal_shutdown <= 1'b0;
        bus(1'b1, 4'h0, 32'h3);
        chop_trip_a <= 1'b1;
        span(1'b0, n1);
        span(1'b1, n1);
        span(1'b0, n1);
        span(1'b1, n1);
        span(1'b0, n2);
        chk("period", n1 + n2, dhbpc_pkg::CHOP_CYC);
        chk("blank", n1 >= dhbpc_pkg::BLANK_CYC &&
            n1 <= dhbpc_pkg::BLANK_CYC + 5, 1);
        {sleep_request_low, code_b} <= {1'b0, 2'h2};
        repeat (5) @(posedge aclk);
        chk("sleep", {va, vb}, 8'h0);
        sleep_request_low <= 1'b1;
        repeat (12) @(posedge aclk);
        chk("waking", vb, 4'h0);
        repeat (30) @(posedge aclk);
        chk("awake", vb, DEC[2]);
        supply_lockout <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("lockout", {va, vb}, 8'h0);
        print_verdict;
    end
    initial begin
        #300000;
        num_errors++;
        print_verdict;
    end
endmodule
